/* shared/dacp_pkg.sv */
`default_nettype none
package dacp_pkg;
   localparam int unsigned DACP_DATA_W     = 12;
   localparam int unsigned DACP_CLK_MHZ    = 100;
   // pin timing figures in ns
   localparam int unsigned DACP_T_SETUP_NS = 10;
   localparam int unsigned DACP_T_CS_NS    = 20;
   localparam int unsigned DACP_T_RD_NS    = 40;
   localparam int unsigned DACP_T_GAP_NS   = 10;
   localparam int unsigned DACP_T_WAIT_NS  = 10;
   localparam int unsigned DACP_SETUP_CYC  = (DACP_T_SETUP_NS * DACP_CLK_MHZ + 999) / 1000;
   localparam int unsigned DACP_CS_CYC     = (DACP_T_CS_NS * DACP_CLK_MHZ + 999) / 1000;
   localparam int unsigned DACP_RD_CYC     = (DACP_T_RD_NS * DACP_CLK_MHZ + 999) / 1000;
   localparam int unsigned DACP_GAP_CYC    = (DACP_T_GAP_NS * DACP_CLK_MHZ + 999) / 1000;
   localparam int unsigned DACP_WAIT_CYC   = (DACP_T_WAIT_NS * DACP_CLK_MHZ + 999) / 1000;
   localparam int unsigned DACP_CNT_W      = 4;
   localparam logic [DACP_DATA_W-1:0] DACP_DATA_RST = 12'h000;
   typedef logic [DACP_DATA_W-1:0] dacp_word_t;
   typedef logic [DACP_CNT_W-1:0]  dacp_cnt_t;
endpackage : dacp_pkg
`default_nettype wire

/* shared/dacp_sync_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface dacp_sync_if;
   import dacp_pkg::*;
   dacp_word_t raw;
   dacp_word_t synced;
   modport sync (input raw, output synced);
   modport user (output raw, input synced);
endinterface : dacp_sync_if
`default_nettype wire

/* core/dacp_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module dacp_sync
   import dacp_pkg::*;
(
   // clock and reset
   input  wire logic    clock_i,
   input  wire logic    rst_n_i,
   // bus to synchronise
   dacp_sync_if.sync    bus
);
   dacp_word_t stage1;
   dacp_word_t stage2;
   dacp_word_t next_stage1;
   dacp_word_t next_stage2;

   always_comb
   begin
      next_stage1 = bus.raw;
      next_stage2 = stage1;
   end

   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         stage1 <= DACP_DATA_RST;
         stage2 <= DACP_DATA_RST;
      end
      else
      begin
         stage1 <= next_stage1;
         stage2 <= next_stage2;
      end
   end

   assign bus.synced = stage2;
endmodule : dacp_sync
`default_nettype wire

/* core/dacp_host.sv */
// Notes on behaviour
// - one whole 12-bit word per transfer
// - write drives data while select and rw low
// - every word gets one select fall and rise
// - read holds rw high while select low
// - optional wait state lengthens each access
// - plain asynchronous memory cycle drives converter
`timescale 1ns/1ps
`default_nettype none
module dacp_host
   import dacp_pkg::*;
(
   // clock and reset
   input  wire logic              clock_i,
   input  wire logic              rst_n_i,
   // user command port
   input  wire logic              wr_req_i,
   input  wire logic              rd_req_i,
   input  wire dacp_pkg::dacp_word_t wr_data_i,
   input  wire logic              wait_en_i,
   output var  logic              busy_o,
   output var  logic              done_o,
   output var  dacp_pkg::dacp_word_t rd_data_o,
   // converter pins
   output var  logic              cs_n_o,
   output var  logic              rw_o,
   output var  dacp_pkg::dacp_word_t parallel_data_lines_o,
   output var  logic              parallel_data_lines_oe_o,
   input  wire dacp_pkg::dacp_word_t parallel_data_lines_i
);
   import dacp_pkg::*;

   typedef enum logic [2:0] {S_IDLE, S_SETUP, S_STROBE, S_WAIT, S_GAP} dacp_state_e;

   dacp_state_e state;
   dacp_state_e next_state;
   dacp_cnt_t   cnt;
   dacp_cnt_t   next_cnt;
   logic        is_read;
   logic        next_is_read;
   logic        cs_n;
   logic        next_cs_n;
   logic        rw;
   logic        next_rw;
   logic        oe;
   logic        next_oe;
   dacp_word_t  dout;
   dacp_word_t  next_dout;
   dacp_word_t  rdata;
   dacp_word_t  next_rdata;
   logic        busy;
   logic        next_busy;
   logic        done;
   logic        next_done;

   dacp_sync_if sync_bus ();
   assign sync_bus.raw = parallel_data_lines_i;

   // the data lines come from another timing domain, so they pass two flops
   dacp_sync u_sync (
      .clock_i (clock_i),
      .rst_n_i (rst_n_i),
      .bus     (sync_bus)
   );

   localparam dacp_cnt_t SETUP_CNT = dacp_cnt_t'(DACP_SETUP_CYC);
   localparam dacp_cnt_t CS_CNT    = dacp_cnt_t'(DACP_CS_CYC);
   // read strobe is stretched to cover the two synchroniser flops
   localparam dacp_cnt_t RD_CNT    = dacp_cnt_t'(DACP_RD_CYC + 2);
   localparam dacp_cnt_t WAIT_CNT  = dacp_cnt_t'(DACP_WAIT_CYC);
   localparam dacp_cnt_t GAP_CNT   = dacp_cnt_t'(DACP_GAP_CYC);

   always_comb
   begin
      next_state   = state;
      next_cnt     = cnt;
      next_is_read = is_read;
      next_cs_n    = cs_n;
      next_rw      = rw;
      next_oe      = oe;
      next_dout    = dout;
      next_rdata   = rdata;
      next_busy    = busy;
      next_done    = 1'b0;
      case (state)
         S_IDLE:
         begin
            // write takes priority if both requests arrive together
            if (wr_req_i || rd_req_i)
            begin
               next_is_read = !wr_req_i;
               next_rw      = !wr_req_i;
               next_oe      = wr_req_i;
               next_dout    = wr_data_i;
               next_busy    = 1'b1;
               next_cnt     = SETUP_CNT;
               next_state   = S_SETUP;
            end
         end
         S_SETUP:
         begin
            if (cnt <= 4'h1)
            begin
               next_cs_n  = 1'b0;
               next_cnt   = is_read ? RD_CNT : CS_CNT;
               next_state = S_STROBE;
            end
            else
               next_cnt = cnt - 4'h1;
         end
         S_STROBE:
         begin
            if (cnt <= 4'h1)
            begin
               if (wait_en_i)
               begin
                  next_cnt   = WAIT_CNT;
                  next_state = S_WAIT;
               end
               else
               begin
                  next_cs_n  = 1'b1;
                  next_cnt   = GAP_CNT;
                  next_state = S_GAP;
                  if (is_read)
                     next_rdata = sync_bus.synced;
               end
            end
            else
               next_cnt = cnt - 4'h1;
         end
         S_WAIT:
         begin
            if (cnt <= 4'h1)
            begin
               next_cs_n  = 1'b1;
               next_cnt   = GAP_CNT;
               next_state = S_GAP;
               if (is_read)
                  next_rdata = sync_bus.synced;
            end
            else
               next_cnt = cnt - 4'h1;
         end
         S_GAP:
         begin
            // data and rw held past the select rise for hold time
            if (cnt <= 4'h1)
            begin
               next_oe    = 1'b0;
               next_rw    = 1'b1;
               next_busy  = 1'b0;
               next_done  = 1'b1;
               next_state = S_IDLE;
            end
            else
               next_cnt = cnt - 4'h1;
         end
         default:
         begin
            next_state = S_IDLE;
            next_cs_n  = 1'b1;
            next_oe    = 1'b0;
            next_busy  = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         state   <= S_IDLE;
         cnt     <= 4'h0;
         is_read <= 1'b0;
         cs_n    <= 1'b1;
         rw      <= 1'b1;
         oe      <= 1'b0;
         dout    <= DACP_DATA_RST;
         rdata   <= DACP_DATA_RST;
         busy    <= 1'b0;
         done    <= 1'b0;
      end
      else
      begin
         state   <= next_state;
         cnt     <= next_cnt;
         is_read <= next_is_read;
         cs_n    <= next_cs_n;
         rw      <= next_rw;
         oe      <= next_oe;
         dout    <= next_dout;
         rdata   <= next_rdata;
         busy    <= next_busy;
         done    <= next_done;
      end
   end

   assign cs_n_o                   = cs_n;
   assign rw_o                     = rw;
   assign parallel_data_lines_o    = dout;
   assign parallel_data_lines_oe_o = oe;
   assign busy_o                   = busy;
   assign done_o                   = done;
   assign rd_data_o                = rdata;

   a_write_drives_data: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      (!cs_n && !rw) |-> oe) else $error("write strobe without data drive");
   a_read_no_drive: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      (!cs_n && rw) |-> !oe) else $error("host drives data during read");
   a_rw_stable_cs: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      (!cs_n && $past(!cs_n)) |-> $stable(rw)) else $error("rw moved under select");
   a_data_stable_cs: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      (!cs_n && $past(!cs_n) && !rw) |-> $stable(dout)) else $error("data moved in write");
   a_cs_pulse_min: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      $fell(cs_n) |-> !cs_n [*2]) else $error("select pulse too short");
   a_cs_rise_done: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      $rose(cs_n) |-> ##[1:16] done) else $error("no done after select rise");
   a_done_one_cycle: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      done |-> !busy ##1 !done) else $error("done not a single pulse");
   a_wait_stretch: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      (state == S_WAIT) |-> !cs_n) else $error("select high during wait");
   a_read_capture: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      ($rose(cs_n) && is_read) |-> rdata == $past(sync_bus.synced)) else $error("read lost");
endmodule : dacp_host
`default_nettype wire

/* test/dacp_dev_model.sv */
`timescale 1ns/1ps
`default_nettype none
module dacp_dev_model
   import dacp_pkg::*;
(
   // host side pins
   input  wire logic                 cs_n_i,
   input  wire logic                 rw_i,
   input  wire dacp_pkg::dacp_word_t host_data_i,
   input  wire logic                 host_oe_i,
   // resolved lines and converter code
   output var  dacp_pkg::dacp_word_t lines_o,
   output var  dacp_pkg::dacp_word_t dac_o
);
   import dacp_pkg::*;
   dacp_word_t input_reg;
   dacp_word_t last;
   initial
   begin
      input_reg = DACP_DATA_RST;
      dac_o = DACP_DATA_RST;
      last = DACP_DATA_RST;
      lines_o = ~DACP_DATA_RST;
   end
   // registers move on select edges only, never transparently
   always @(negedge cs_n_i)
      if (rw_i) input_reg = dac_o;
   always @(posedge cs_n_i)
      if (!rw_i)
      begin
         input_reg = host_data_i;
         dac_o = input_reg;
      end
   // released lines float, so show the inverse of the last level
   always @(host_oe_i, cs_n_i, rw_i, host_data_i, dac_o)
      if (host_oe_i)
      begin
         lines_o = host_data_i;
         last = host_data_i;
      end
      else if (!cs_n_i && rw_i)
      begin
         lines_o = dac_o;
         last = dac_o;
      end
      else
         lines_o = ~last;
endmodule : dacp_dev_model
`default_nettype wire

/* test/dac_parallel_load_readback_port_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module dac_parallel_load_readback_port_tb;
   import dacp_pkg::*;
   logic       clock_i = 1'b0;
   logic       rst_n_i = 1'b0;
   logic       wr_req_i = 1'b0;
   logic       rd_req_i = 1'b0;
   logic       wait_en_i = 1'b0;
   logic       busy_o, done_o, cs_n_o, rw_o, oe;
   dacp_word_t wr_data_i = '0;
   dacp_word_t rd_data_o, host_data, lines, dac;
   int         num_errors = 0;
   int         compares = 0;
   logic [12:0] rows [4] = '{13'h0fff, 13'h1800, 13'h0001, 13'h1a5c};
   always #5 clock_i = ~clock_i;
   dacp_host dut_u (.clock_i(clock_i), .rst_n_i(rst_n_i), .wr_req_i(wr_req_i),
      .rd_req_i(rd_req_i), .wr_data_i(wr_data_i), .wait_en_i(wait_en_i), .busy_o(busy_o),
      .done_o(done_o), .rd_data_o(rd_data_o), .cs_n_o(cs_n_o), .rw_o(rw_o),
      .parallel_data_lines_o(host_data), .parallel_data_lines_oe_o(oe),
      .parallel_data_lines_i(lines));
   dacp_dev_model dev_u (.cs_n_i(cs_n_o), .rw_i(rw_o), .host_data_i(host_data),
      .host_oe_i(oe), .lines_o(lines), .dac_o(dac));
   task automatic report_and_stop;
      $display("errors %0d compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : report_and_stop
   task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
      compares++;
      if (got !== exp)
      begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   // called at a falling edge; poke raises a read while the access is busy
   task automatic access(input logic wr, input logic rd, input dacp_word_t w,
                         input logic wt, input logic poke, input int exp_n);
      int n;
      wr_req_i = wr;
      rd_req_i = rd;
      wr_data_i = w;
      wait_en_i = wt;
      @(negedge clock_i);
      wr_req_i = 1'b0;
      rd_req_i = 1'b0;
      n = 1;
      while (done_o !== 1'b1 && n < 40)
      begin
         @(negedge clock_i);
         n++;
         rd_req_i = poke && n == 2;
      end
      if (n >= 40)
      begin
         num_errors++;
         report_and_stop();
      end
      else
         chk("latency", 12'(exp_n), 12'(n));
   endtask : access
   initial
   begin
      repeat (20) @(negedge clock_i);
      chk("cs_n in reset", 12'h001, {11'h000, cs_n_o});
      chk("rw in reset", 12'h001, {11'h000, rw_o});
      chk("oe busy done", 12'h000, {9'h000, oe, busy_o, done_o});
      rst_n_i = 1'b1;
      access(1'b0, 1'b1, 12'h000, 1'b0, 1'b0, 9);
      chk("power-up readback", 12'h000, rd_data_o);
      $display("reset test done");
      for (int i = 0; i < 4; i++)
      begin
         access(1'b1, 1'b0, rows[i][11:0], rows[i][12], 1'b0, 5 + rows[i][12]);
         chk("converter code", rows[i][11:0], dac);
         access(1'b0, 1'b1, 12'h000, rows[i][12], 1'b0, 9 + rows[i][12]);
         chk("readback", rows[i][11:0], rd_data_o);
         $display("row %0d done", i);
      end
      access(1'b1, 1'b1, 12'h3c3, 1'b0, 1'b1, 5);
      chk("write wins", 12'h3c3, dac);
      @(negedge clock_i);
      chk("busy after refused", 12'h000, {11'h000, busy_o});
      chk("readback kept", 12'ha5c, rd_data_o);
      $display("awkward tests done");
      report_and_stop();
   end
endmodule : dac_parallel_load_readback_port_tb
`default_nettype wire
